// *** bsp_consts.svh ***
// Function
// RULE1: propagate pin: carry propagate, else logic greater
// RULE2: ripple carry output is active low
// RULE3: zero detect high on zero sum, open collector
// RULE4: load accumulator from operand A when load low
// RULE5: primary accumulator shift pins, true polarity
// RULE6: extension shifts alike; single/double, signed/unsigned
// RULE7: two selects choose data-out source or off
// RULE8: data-out port four bits, three-state, bit0 lsb
// RULE9: memory counter steps when its step low
// RULE10: program counter steps when its step low
// RULE11: controller never enables both counters together
// RULE12: counter carry low when enabled counter maximum
// RULE13: high slice: carry pin shows coming overflow
// RULE14: address select picks program or memory counter
// RULE15: low slice: carry input picks step one/two
// RULE16: other slices: carry input low carries, high holds
// RULE17: operand latches follow inputs, hold captured data
// RULE18: registers and counters change on rising edge
// RULE19: b direction low drives sum, high releases
// RULE20: generate pin: carry generate, else arith greater
// RULE21: rank input selects low, middle or high role
// RULE22: ripple carry input is active low
// RULE23: four-bit counters cascade through counter carry
// RULE24: counter wraps at maximum, carry passes on
`ifndef BSP_CONSTS_SVH
`define BSP_CONSTS_SVH
`define BSP_NIB_RST 4'h0
`define BSP_NIB_ZERO 4'h0
`define BSP_CNT_MAX 4'hF
`define BSP_STEP_NONE 5'h00
`define BSP_STEP_ONE 5'h01
`define BSP_STEP_TWO 5'h02
`define BSP_DSEL_WR 2'h0
`define BSP_DSEL_XWR 2'h1
`define BSP_DSEL_SUM 2'h2
`define BSP_DSEL_OFF 2'h3
`define BSP_SYNC_W 30
`define BSP_SYNC_IDLE 30'h0009803E
`endif

// *** bsp_pkg.sv ***
package bsp_pkg;
  typedef enum logic [1:0] {BSP_RANK_LOW, BSP_RANK_MID, BSP_RANK_HIGH} bsp_rank_t;
  typedef enum logic [1:0] {BSP_ALU_ADD, BSP_ALU_SUB, BSP_ALU_AND, BSP_ALU_XOR} bsp_alu_t;
  typedef enum logic [1:0] {BSP_SH_NONE, BSP_SH_RIGHT, BSP_SH_LEFT} bsp_shift_t;
endpackage : bsp_pkg

// *** bsp_sync2.sv ***
`timescale 1ns/10ps
module bsp_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds the second stage only
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : bsp_sync2

// *** bsp_slice.sv ***
`timescale 1ns/10ps
`include "bsp_consts.svh"
module bsp_slice
  import bsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // slice role
  input wire logic [1:0] slice_rank,
  // operand ports
  input wire logic [3:0] operand_a_port,
  input wire logic [3:0] b_bidirectional_port_in,
  output logic [3:0] b_bidirectional_port_out,
  output logic b_bidirectional_port_oe,
  input wire logic b_port_direction_select,
  // alu control and carry chain
  input wire logic [1:0] alu_function,
  input wire logic ripple_carry_input_n,
  output logic ripple_carry_output_n,
  output logic propagate_or_logic_greater,
  output logic generate_or_arith_greater,
  output logic zero_detect_out,
  output logic zero_detect_out_oe,
  // accumulators
  input wire logic accumulator_load_n,
  input wire logic [1:0] shift_direction,
  input wire logic shift_double,
  input wire logic shift_signed,
  input wire logic shift_target_ext,
  // shift interconnect pins
  input wire logic accum_right_shift_pin_in,
  output logic accum_right_shift_pin_out,
  output logic accum_right_shift_pin_oe,
  input wire logic accum_left_shift_pin_in,
  output logic accum_left_shift_pin_out,
  output logic accum_left_shift_pin_oe,
  input wire logic ext_accum_right_shift_pin_in,
  output logic ext_accum_right_shift_pin_out,
  output logic ext_accum_right_shift_pin_oe,
  input wire logic ext_accum_left_shift_pin_in,
  output logic ext_accum_left_shift_pin_out,
  output logic ext_accum_left_shift_pin_oe,
  // data out port
  input wire logic data_out_select_low,
  input wire logic data_out_select_high,
  output logic [3:0] data_out_port,
  output logic data_out_port_oe,
  // counters and address port
  input wire logic memory_counter_step_n,
  input wire logic program_counter_step_n,
  input wire logic counter_carry_input,
  output logic counter_carry_or_overflow,
  input wire logic address_source_select,
  output logic [3:0] address_out_port
);

  // synchronised pin levels
  logic [`BSP_SYNC_W-1:0] pins_raw;
  logic [`BSP_SYNC_W-1:0] pins_s;
  logic [1:0] rank_s;
  logic [3:0] a_s;
  logic [3:0] b_s;
  logic bsel_s;
  logic [1:0] func_s;
  logic cin_n_s;
  logic load_n_s;
  logic [1:0] shdir_s;
  logic dbl_s;
  logic sgn_s;
  logic tgt_s;
  logic wr_rt_s;
  logic wr_lf_s;
  logic x_rt_s;
  logic x_lf_s;
  logic [1:0] dsel_s;
  logic mc_step_n_s;
  logic pc_step_n_s;
  logic cci_s;
  logic asel_s;

  // synchroniser flops clear to zero; the mask makes that mean every pin idle,
  // so no load, step or bus drive fires in the two edges after reset
  assign pins_raw = {slice_rank, operand_a_port, b_bidirectional_port_in,
                     b_port_direction_select, alu_function, ripple_carry_input_n,
                     accumulator_load_n, shift_direction, shift_double, shift_signed,
                     shift_target_ext, accum_right_shift_pin_in, accum_left_shift_pin_in,
                     ext_accum_right_shift_pin_in, ext_accum_left_shift_pin_in,
                     data_out_select_high, data_out_select_low, memory_counter_step_n,
                     program_counter_step_n, counter_carry_input, address_source_select}
                     ^ `BSP_SYNC_IDLE;

  bsp_sync2 #(
    .WIDTH(`BSP_SYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign {rank_s, a_s, b_s, bsel_s, func_s, cin_n_s, load_n_s, shdir_s, dbl_s, sgn_s,
          tgt_s, wr_rt_s, wr_lf_s, x_rt_s, x_lf_s, dsel_s, mc_step_n_s, pc_step_n_s,
          cci_s, asel_s} = pins_s ^ `BSP_SYNC_IDLE;

  // decoded controls
  bsp_rank_t rank;
  bsp_alu_t func;
  bsp_shift_t dir;
  logic is_high;
  logic is_low;

  // three-level role; an unused code falls back to the middle role
  always_comb begin
    rank = bsp_rank_t'(rank_s);
    func = bsp_alu_t'(func_s);
    dir = bsp_shift_t'(shdir_s);
    is_high = (rank == BSP_RANK_HIGH); // [RULE21]
    is_low = (rank == BSP_RANK_LOW); // [RULE21]
  end

  function automatic logic [3:0] shift4(input logic [3:0] r, input bsp_shift_t d,
                                        input logic from_left, input logic from_right,
                                        input logic keep_sign);
    logic [3:0] res;
    res = r;
    unique case (d)
      BSP_SH_RIGHT: res = keep_sign ? {r[3], r[3:1]} : {from_left, r[3:1]};
      BSP_SH_LEFT: res = keep_sign ? {r[3], r[1:0], from_right} : {r[2:0], from_right};
      default: res = r;
    endcase
    return res;
  endfunction : shift4

  // operand latches, sum bus and accumulators
  logic [3:0] a_lat_q, a_lat_d;
  logic [3:0] b_lat_q, b_lat_d;
  logic [3:0] wr_q, wr_d;
  logic [3:0] xwr_q, xwr_d;
  logic [3:0] bb;
  logic [3:0] sum;
  logic [4:0] s5;
  logic [3:0] s3;
  logic arith;
  logic alu_ripple_carry_output_n;
  logic alu_v;
  logic grp_p;
  logic grp_g;
  logic wr_shift;
  logic x_shift;
  logic wr_keep;
  logic x_keep;
  logic shift_v;

  always_comb begin
    // the A latch follows its pins every edge, the B latch only while the b port is released; data is held between edges
    a_lat_d = a_s; // [RULE17]
    b_lat_d = bsel_s ? b_s : b_lat_q; // [RULE17] [RULE19]
    arith = (func == BSP_ALU_ADD) || (func == BSP_ALU_SUB);
    bb = (func == BSP_ALU_SUB) ? ~b_lat_q : b_lat_q;
    s5 = {1'b0, a_lat_q} + {1'b0, bb} + {4'h0, ~cin_n_s}; // [RULE22]
    s3 = {1'b0, a_lat_q[2:0]} + {1'b0, bb[2:0]} + {3'h0, ~cin_n_s};
    unique case (func)
      BSP_ALU_ADD: sum = s5[3:0];
      BSP_ALU_SUB: sum = s5[3:0];
      BSP_ALU_AND: sum = a_lat_q & b_lat_q;
      BSP_ALU_XOR: sum = a_lat_q ^ b_lat_q;
    endcase
    alu_ripple_carry_output_n = arith & s5[4];
    alu_v = arith & (s5[4] ^ s3[3]);
    grp_p = &(a_lat_q | bb);
    grp_g = (a_lat_q[3] & bb[3])
          | ((a_lat_q[3] | bb[3]) & a_lat_q[2] & bb[2])
          | ((a_lat_q[3] | bb[3]) & (a_lat_q[2] | bb[2]) & a_lat_q[1] & bb[1])
          | ((a_lat_q[3] | bb[3]) & (a_lat_q[2] | bb[2]) & (a_lat_q[1] | bb[1])
             & a_lat_q[0] & bb[0]);
    // single precision shifts one accumulator, double shifts both
    wr_shift = (dir == BSP_SH_RIGHT || dir == BSP_SH_LEFT) && (dbl_s || !tgt_s); // [RULE6]
    x_shift = (dir == BSP_SH_RIGHT || dir == BSP_SH_LEFT) && (dbl_s || tgt_s); // [RULE6]
    // the sign lives in the high slice of whichever register leads
    wr_keep = sgn_s && is_high && wr_shift; // [RULE6]
    x_keep = sgn_s && is_high && x_shift && !dbl_s; // [RULE6]
    if (!load_n_s) begin
      wr_d = a_s; // [RULE4]
    end else if (wr_shift) begin
      wr_d = shift4(wr_q, dir, wr_lf_s, wr_rt_s, wr_keep); // [RULE5]
    end else begin
      wr_d = wr_q;
    end
    xwr_d = x_shift ? shift4(xwr_q, dir, x_lf_s, x_rt_s, x_keep) : xwr_q; // [RULE6]
    // a left shift that loses the top bit, or changes the sign, overflows
    shift_v = 1'b0;
    if (dir == BSP_SH_LEFT) begin
      if (wr_shift) begin
        shift_v = wr_keep ? (wr_q[3] ^ wr_q[2]) : wr_q[3];
      end else begin
        shift_v = x_keep ? (xwr_q[3] ^ xwr_q[2]) : xwr_q[3];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin // [RULE18]
    if (!rst_b) begin
      a_lat_q <= `BSP_NIB_RST;
      b_lat_q <= `BSP_NIB_RST;
      wr_q <= `BSP_NIB_RST;
      xwr_q <= `BSP_NIB_RST;
    end else begin
      a_lat_q <= a_lat_d;
      b_lat_q <= b_lat_d;
      wr_q <= wr_d;
      xwr_q <= xwr_d;
    end
  end

  // program and memory counters
  logic [3:0] pc_q, pc_d;
  logic [3:0] mc_q, mc_d;
  logic [4:0] step;
  logic [4:0] pc_sum;
  logic [4:0] mc_sum;
  logic pc_en;
  logic mc_en;

  always_comb begin
    pc_en = !pc_step_n_s; // [RULE10]
    mc_en = !mc_step_n_s; // [RULE9]
    if (is_low) begin
      step = cci_s ? `BSP_STEP_TWO : `BSP_STEP_ONE; // [RULE15]
    end else begin
      step = cci_s ? `BSP_STEP_NONE : `BSP_STEP_ONE; // [RULE16]
    end
    // five-bit sums drop the carry, so a full counter wraps round
    pc_sum = {1'b0, pc_q} + step; // [RULE24]
    mc_sum = {1'b0, mc_q} + step; // [RULE24]
    pc_d = pc_en ? pc_sum[3:0] : pc_q; // [RULE10] [RULE23]
    mc_d = mc_en ? mc_sum[3:0] : mc_q; // [RULE9] [RULE23]
  end

  always_ff @(posedge clk or negedge rst_b) begin // [RULE18]
    if (!rst_b) begin
      pc_q <= `BSP_NIB_RST;
      mc_q <= `BSP_NIB_RST;
    end else begin
      pc_q <= pc_d;
      mc_q <= mc_d;
    end
  end

  // registered pins
  logic rcout_n_q, rcout_n_d;
  logic prop_q, prop_d;
  logic gen_q, gen_d;
  logic zero_oe_q, zero_oe_d;
  logic [3:0] bout_q, bout_d;
  logic boe_q, boe_d;
  logic [3:0] dop_q, dop_d;
  logic dop_oe_q, dop_oe_d;
  logic cco_q, cco_d;
  logic [3:0] aop_q, aop_d;
  logic wr_rt_q, wr_rt_d;
  logic wr_rt_oe_q, wr_rt_oe_d;
  logic wr_lf_q, wr_lf_d;
  logic wr_lf_oe_q, wr_lf_oe_d;
  logic x_rt_q, x_rt_d;
  logic x_rt_oe_q, x_rt_oe_d;
  logic x_lf_q, x_lf_d;
  logic x_lf_oe_q, x_lf_oe_d;

  // pins register this edge's next state or the sum of the latches, so they trail the input pins by three or four cycles
  always_comb begin
    rcout_n_d = !alu_ripple_carry_output_n; // [RULE2]
    prop_d = is_high ? (a_lat_q > b_lat_q) : grp_p; // [RULE1]
    gen_d = is_high ? ($signed(a_lat_q) > $signed(b_lat_q)) : grp_g; // [RULE20]
    zero_oe_d = (sum != `BSP_NIB_ZERO); // [RULE3]
    boe_d = !bsel_s; // [RULE19]
    bout_d = sum; // [RULE19]
    unique case ({dsel_s})
      `BSP_DSEL_WR: dop_d = wr_d; // [RULE7]
      `BSP_DSEL_XWR: dop_d = xwr_d; // [RULE7]
      `BSP_DSEL_SUM: dop_d = sum; // [RULE7]
      `BSP_DSEL_OFF: dop_d = dop_q; // [RULE7]
    endcase
    dop_oe_d = (dsel_s != `BSP_DSEL_OFF); // [RULE8]
    aop_d = asel_s ? mc_d : pc_d; // [RULE14]
    if (is_high) begin
      cco_d = (dir == BSP_SH_LEFT) ? shift_v : alu_v; // [RULE13]
    end else begin
      // both counters enabled at once gives an ambiguous carry
      cco_d = !((pc_en && pc_d == `BSP_CNT_MAX) || (mc_en && mc_d == `BSP_CNT_MAX)); // [RULE12]
    end
    // a pin drives only the bit leaving on its side
    wr_rt_oe_d = wr_shift && (dir == BSP_SH_RIGHT); // [RULE5]
    wr_lf_oe_d = wr_shift && (dir == BSP_SH_LEFT); // [RULE5]
    x_rt_oe_d = x_shift && (dir == BSP_SH_RIGHT); // [RULE6]
    x_lf_oe_d = x_shift && (dir == BSP_SH_LEFT); // [RULE6]
    wr_rt_d = wr_d[0]; // [RULE5]
    wr_lf_d = wr_d[3]; // [RULE5]
    x_rt_d = xwr_d[0]; // [RULE6]
    x_lf_d = xwr_d[3]; // [RULE6]
  end

  always_ff @(posedge clk or negedge rst_b) begin // [RULE18]
    if (!rst_b) begin
      rcout_n_q <= 1'b1;
      prop_q <= 1'b0;
      gen_q <= 1'b0;
      zero_oe_q <= 1'b0;
      bout_q <= `BSP_NIB_RST;
      boe_q <= 1'b0;
      dop_q <= `BSP_NIB_RST;
      dop_oe_q <= 1'b0;
      cco_q <= 1'b1;
      aop_q <= `BSP_NIB_RST;
      wr_rt_q <= 1'b0;
      wr_rt_oe_q <= 1'b0;
      wr_lf_q <= 1'b0;
      wr_lf_oe_q <= 1'b0;
      x_rt_q <= 1'b0;
      x_rt_oe_q <= 1'b0;
      x_lf_q <= 1'b0;
      x_lf_oe_q <= 1'b0;
    end else begin
      rcout_n_q <= rcout_n_d;
      prop_q <= prop_d;
      gen_q <= gen_d;
      zero_oe_q <= zero_oe_d;
      bout_q <= bout_d;
      boe_q <= boe_d;
      dop_q <= dop_d;
      dop_oe_q <= dop_oe_d;
      cco_q <= cco_d;
      aop_q <= aop_d;
      wr_rt_q <= wr_rt_d;
      wr_rt_oe_q <= wr_rt_oe_d;
      wr_lf_q <= wr_lf_d;
      wr_lf_oe_q <= wr_lf_oe_d;
      x_rt_q <= x_rt_d;
      x_rt_oe_q <= x_rt_oe_d;
      x_lf_q <= x_lf_d;
      x_lf_oe_q <= x_lf_oe_d;
    end
  end

  // open collector: value low, enable set when the sum is nonzero
  assign zero_detect_out = 1'b0; // [RULE3]
  assign zero_detect_out_oe = zero_oe_q;
  assign ripple_carry_output_n = rcout_n_q;
  assign propagate_or_logic_greater = prop_q;
  assign generate_or_arith_greater = gen_q;
  assign b_bidirectional_port_out = bout_q;
  assign b_bidirectional_port_oe = boe_q;
  assign data_out_port = dop_q;
  assign data_out_port_oe = dop_oe_q;
  assign counter_carry_or_overflow = cco_q;
  assign address_out_port = aop_q;
  assign accum_right_shift_pin_out = wr_rt_q;
  assign accum_right_shift_pin_oe = wr_rt_oe_q;
  assign accum_left_shift_pin_out = wr_lf_q;
  assign accum_left_shift_pin_oe = wr_lf_oe_q;
  assign ext_accum_right_shift_pin_out = x_rt_q;
  assign ext_accum_right_shift_pin_oe = x_rt_oe_q;
  assign ext_accum_left_shift_pin_out = x_lf_q;
  assign ext_accum_left_shift_pin_oe = x_lf_oe_q;

endmodule : bsp_slice

// *** bsp_slice_assertions.sv ***
`timescale 1ns/10ps
module bsp_slice_assertions
  import bsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // controls
  input wire logic [1:0] slice_rank,
  input wire logic [3:0] operand_a_port,
  input wire logic [1:0] alu_function,
  input wire logic accumulator_load_n,
  input wire logic b_port_direction_select,
  input wire logic data_out_select_low,
  input wire logic data_out_select_high,
  input wire logic program_counter_step_n,
  input wire logic memory_counter_step_n,
  input wire logic counter_carry_input,
  input wire logic address_source_select,
  // results
  input wire logic ripple_carry_output_n,
  input wire logic zero_detect_out,
  input wire logic zero_detect_out_oe,
  input wire logic [3:0] b_bidirectional_port_out,
  input wire logic b_bidirectional_port_oe,
  input wire logic [3:0] data_out_port,
  input wire logic data_out_port_oe,
  input wire logic counter_carry_or_overflow,
  input wire logic [3:0] address_out_port
);
  logic [3:0] up_q;
  logic [3:0] up_d;
  logic ok;
  logic idle;
  logic c_one;
  logic c_mid;
  logic [1:0] dsel;
  // inputs cross a two-flop synchroniser, so causes sit three samples back;
  // ok waits until every $past below sees post-reset values
  assign ok = up_q >= 4'h5;
  assign dsel = {data_out_select_high, data_out_select_low};
  assign idle = program_counter_step_n && memory_counter_step_n;
  assign c_one = slice_rank == BSP_RANK_LOW && !program_counter_step_n && memory_counter_step_n
    && !counter_carry_input && !address_source_select;
  assign c_mid = slice_rank == BSP_RANK_MID && !program_counter_step_n && memory_counter_step_n
    && counter_carry_input && !address_source_select;
  always_comb begin
    up_d = (up_q == 4'hF) ? up_q : up_q + 4'h1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_q <= 4'h0;
    end else begin
      up_q <= up_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  zero_oc_a: assert property (!zero_detect_out)
    else $error("zero detect drove high");
  zero_sum_a: assert property (ok |-> zero_detect_out_oe == (b_bidirectional_port_out != 4'h0))
    else $error("zero detect disagrees with sum");
  carry_logic_a: assert property (ok && $past(alu_function[1], 3) && $past(alu_function[1], 4)
    && $past(alu_function[1], 5) |-> ripple_carry_output_n) else $error("carry on logic op");
  acc_load_a: assert property (ok && $past(!accumulator_load_n, 3) && $past(dsel, 3) == 2'h0
    |-> data_out_port == $past(operand_a_port, 3)) else $error("load value not shown");
  dop_sel_a: assert property (ok && $past(dsel, 3) == $past(dsel, 4)
    |-> data_out_port_oe == ($past(dsel, 3) != 2'h3)) else $error("data out enable wrong");
  dop_hold_a: assert property (ok && !data_out_port_oe && $past(!data_out_port_oe)
    |-> $stable(data_out_port)) else $error("data out moved while off");
  addr_hold_a: assert property (ok && $past(idle, 3)
    && $past(address_source_select, 3) == $past(address_source_select, 4)
    |-> $stable(address_out_port)) else $error("address moved while idle");
  pc_one_a: assert property (ok && $past(c_one, 2) && $past(c_one, 3) && $past(c_one, 4)
    |-> address_out_port == $past(address_out_port) + 4'h1) else $error("step by one wrong");
  mid_hold_a: assert property (ok && $past(c_mid, 2) && $past(c_mid, 3) && $past(c_mid, 4)
    |-> $stable(address_out_port)) else $error("inhibited counter moved");
  b_dir_a: assert property (ok && $past(b_port_direction_select, 3)
    == $past(b_port_direction_select, 4) |-> b_bidirectional_port_oe
    == !$past(b_port_direction_select, 3)) else $error("b direction wrong");
  cco_idle_a: assert property (ok && $past(idle && slice_rank == BSP_RANK_LOW, 3)
    && $past(idle && slice_rank == BSP_RANK_LOW, 4) |-> counter_carry_or_overflow)
    else $error("counter carry low with no counter enabled");
  cover property (ok && !accumulator_load_n);
  cover property (!b_bidirectional_port_oe ##1 b_bidirectional_port_oe);
  cover property (address_out_port == 4'hF ##[1:8] address_out_port == 4'h0);
endmodule : bsp_slice_assertions
bind bsp_slice bsp_slice_assertions bsp_slice_assertions_inst (.*);

// *** bsp_nbr_model.sv ***
`timescale 1ns/10ps
module bsp_nbr_model (
  // bits the neighbouring slices shift in
  input wire logic left_bit,
  input wire logic right_bit,
  // slice shift pins
  input wire logic accum_right_shift_pin_out,
  input wire logic accum_right_shift_pin_oe,
  input wire logic accum_left_shift_pin_out,
  input wire logic accum_left_shift_pin_oe,
  input wire logic ext_accum_right_shift_pin_out,
  input wire logic ext_accum_right_shift_pin_oe,
  input wire logic ext_accum_left_shift_pin_out,
  input wire logic ext_accum_left_shift_pin_oe,
  output logic accum_right_shift_pin_in,
  output logic accum_left_shift_pin_in,
  output logic ext_accum_right_shift_pin_in,
  output logic ext_accum_left_shift_pin_in
);
  // neighbour drives true data; the slice wins the wire while it drives
  assign accum_right_shift_pin_in = accum_right_shift_pin_oe ? accum_right_shift_pin_out
    : right_bit;
  assign accum_left_shift_pin_in = accum_left_shift_pin_oe ? accum_left_shift_pin_out
    : left_bit;
  assign ext_accum_right_shift_pin_in = ext_accum_right_shift_pin_oe
    ? ext_accum_right_shift_pin_out : right_bit;
  assign ext_accum_left_shift_pin_in = ext_accum_left_shift_pin_oe
    ? ext_accum_left_shift_pin_out : left_bit;
endmodule : bsp_nbr_model

// *** test_bsp_slice.sv ***
`timescale 1ns/10ps
module test_bsp_slice
  import bsp_pkg::*;
  ;
  logic clk, rst_b, accumulator_load_n, shift_double, shift_signed, shift_target_ext;
  logic b_port_direction_select, ripple_carry_input_n, data_out_select_low;
  logic data_out_select_high, memory_counter_step_n, program_counter_step_n;
  logic counter_carry_input, address_source_select, left_bit, right_bit, zero_wire;
  logic [1:0] slice_rank, alu_function, shift_direction;
  logic [3:0] operand_a_port, b_drive, b_bidirectional_port_in, b_bidirectional_port_out;
  logic [3:0] data_out_port, address_out_port;
  logic [3:0] dop_exp [4];
  logic b_bidirectional_port_oe, ripple_carry_output_n, propagate_or_logic_greater;
  logic generate_or_arith_greater, zero_detect_out, zero_detect_out_oe;
  logic data_out_port_oe, counter_carry_or_overflow;
  logic accum_right_shift_pin_in, accum_right_shift_pin_out, accum_right_shift_pin_oe;
  logic accum_left_shift_pin_in, accum_left_shift_pin_out, accum_left_shift_pin_oe;
  logic ext_accum_right_shift_pin_in, ext_accum_right_shift_pin_out;
  logic ext_accum_right_shift_pin_oe, ext_accum_left_shift_pin_in;
  logic ext_accum_left_shift_pin_out, ext_accum_left_shift_pin_oe;
  int n_mismatch, n_checks;
  bsp_slice bsp_slice_inst (.*);
  bsp_nbr_model bsp_nbr_model_inst (.*);
  // b pins and the open-collector zero line resolved from every driver
  assign b_bidirectional_port_in = b_bidirectional_port_oe ? b_bidirectional_port_out : b_drive;
  assign zero_wire = zero_detect_out_oe ? zero_detect_out : 1'b1;
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask : run
  // only one counter enabled at a time, the shared carry would be ambiguous
  task automatic step(input logic pc, input int n);
    program_counter_step_n = !pc;
    memory_counter_step_n = pc;
    run(n);
    program_counter_step_n = 1'b1;
    memory_counter_step_n = 1'b1;
    run(5);
  endtask : step
  task automatic summarize;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    dop_exp = '{4'hC, 4'h1, 4'h7, 4'h7};
    rst_b = 1'b0;
    {slice_rank, alu_function, shift_direction, shift_double, shift_signed} = '0;
    {shift_target_ext, operand_a_port, b_drive, left_bit, right_bit} = '0;
    {data_out_select_high, data_out_select_low, address_source_select} = '0;
    {counter_carry_input, accumulator_load_n, b_port_direction_select} = 3'h3;
    {ripple_carry_input_n, program_counter_step_n, memory_counter_step_n} = 3'h7;
    run(4);
    chk("carry_n_rst", {3'h0, ripple_carry_output_n}, 4'h1);
    chk("aop_rst", address_out_port, 4'h0);
    run(1);
    rst_b = 1'b1;
    run(3);
    // load 9, shift right taking a one from the left, extension shifts a one in
    operand_a_port = 4'h9;
    accumulator_load_n = 1'b0;
    run(1);
    accumulator_load_n = 1'b1;
    {left_bit, right_bit, shift_direction} = 4'hD;
    run(1);
    shift_target_ext = 1'b1;
    shift_direction = 2'h2;
    run(1);
    shift_direction = 2'h0;
    operand_a_port = 4'h3;
    b_drive = 4'h4;
    run(6);
    b_port_direction_select = 1'b0;
    run(6);
    chk("b_out", b_bidirectional_port_in, 4'h7);
    chk("zero", {3'h0, zero_wire}, 4'h0);
    chk("carry_n", {3'h0, ripple_carry_output_n}, 4'h1);
    chk("xy", {2'h0, propagate_or_logic_greater, generate_or_arith_greater}, 4'h0);
    for (int i = 0; i < 4; i++) begin
      {data_out_select_high, data_out_select_low} = i[1:0];
      run(5);
      chk("dop", data_out_port, dop_exp[i]);
      chk("dop_oe", {3'h0, data_out_port_oe}, {3'h0, i != 3});
    end
    // sum of zero with carry out, then magnitude compare in the high slice
    b_port_direction_select = 1'b1;
    operand_a_port = 4'hF;
    b_drive = 4'h1;
    // the latch still sees the slice's own drive until the turnaround has passed
    run(8);
    chk("b_oe", {3'h0, b_bidirectional_port_oe}, 4'h0);
    chk("zero", {3'h0, zero_wire}, 4'h1);
    chk("carry_n", {3'h0, ripple_carry_output_n}, 4'h0);
    chk("xy", {2'h0, propagate_or_logic_greater, generate_or_arith_greater}, 4'h3);
    slice_rank = BSP_RANK_HIGH;
    run(6);
    chk("gt", {2'h0, propagate_or_logic_greater, generate_or_arith_greater}, 4'h2);
    operand_a_port = 4'h1;
    b_drive = 4'hF;
    run(6);
    chk("gt", {2'h0, propagate_or_logic_greater, generate_or_arith_greater}, 4'h1);
    slice_rank = BSP_RANK_LOW;
    alu_function = 2'h3;
    {data_out_select_high, data_out_select_low} = 2'h2;
    run(6);
    chk("xor", data_out_port, 4'hE);
    // counters, low slice then middle slice
    counter_carry_input = 1'b0;
    step(1'b1, 3);
    chk("pc", address_out_port, 4'h3);
    counter_carry_input = 1'b1;
    step(1'b1, 2);
    chk("pc", address_out_port, 4'h7);
    address_source_select = 1'b1;
    counter_carry_input = 1'b0;
    run(4);
    chk("mc", address_out_port, 4'h0);
    step(1'b0, 15);
    chk("mc", address_out_port, 4'hF);
    slice_rank = BSP_RANK_MID;
    counter_carry_input = 1'b1;
    memory_counter_step_n = 1'b0;
    run(5);
    chk("cco", {3'h0, counter_carry_or_overflow}, 4'h0);
    chk("mc", address_out_port, 4'hF);
    slice_rank = BSP_RANK_LOW;
    counter_carry_input = 1'b0;
    step(1'b0, 1);
    chk("mc", address_out_port, 4'h0);
    address_source_select = 1'b0;
    slice_rank = BSP_RANK_MID;
    counter_carry_input = 1'b1;
    run(4);
    step(1'b1, 3);
    chk("pc", address_out_port, 4'h7);
    counter_carry_input = 1'b0;
    step(1'b1, 1);
    chk("pc", address_out_port, 4'h8);
    summarize();
  end
endmodule : test_bsp_slice
